// ### hdl/irq_prio_regs.vh
// Register offsets, field positions and reset values of the interrupt enable/priority block
`ifndef IRQ_PRIO_REGS_VH
`define IRQ_PRIO_REGS_VH

// ***************************************
// Register offsets
// ***************************************
`define BASIC_IRQ_PRIORITY_ADDR 8'hb8
`define EXT_IRQ_ENABLE_ONE_ADDR 8'he6
`define EXT_IRQ_PRIORITY_ONE_ADDR 8'hf6

// ***************************************
// Page restrictions
// ***************************************
`define SFR_PAGE_ZERO 8'h00
`define SFR_PAGE_CONFIG 8'h0f

// ***************************************
// Reset values
// ***************************************
`define BASIC_IRQ_PRIORITY_RST 7'h00
`define EXT_IRQ_ENABLE_ONE_RST 8'h00
`define EXT_IRQ_PRIORITY_ONE_RST 8'h00
`define BASIC_PRIO_UNUSED_READ 1'b1

// ***************************************
// Basic priority fields
// ***************************************
`define EXT_ZERO_IRQ_PRIO_BIT 0
`define TIMER_ZERO_IRQ_PRIO_BIT 1
`define EXT_ONE_IRQ_PRIO_BIT 2
`define TIMER_ONE_IRQ_PRIO_BIT 3
`define UART_IRQ_PRIO_BIT 4
`define TIMER_TWO_IRQ_PRIO_BIT 5
`define SERIAL_PORT_IRQ_PRIO_BIT 6
`define BASIC_PRIO_UNUSED_BIT 7

// ***************************************
// Extended enable and priority fields
// ***************************************
`define TWO_WIRE_IRQ_BIT 0
`define WINDOW_IRQ_BIT 1
`define CONV_DONE_IRQ_BIT 2
`define COUNTER_ARRAY_IRQ_BIT 3
`define CMP_ZERO_IRQ_BIT 4
`define CMP_ONE_IRQ_BIT 5
`define TIMER_THREE_IRQ_BIT 6
`define LIN_IRQ_BIT 7

// ***************************************
// Source numbering
// ***************************************
`define IRQ_SOURCES 15
`define IRQ_NUM_W 4
`define EXT_SOURCE_BASE 7

`endif

// ### hdl/irq_pick.v
// Lowest-numbered pending source finder
`timescale 1ns/10ps
`include "irq_prio_regs.vh"

module irq_pick (
    input wire [`IRQ_SOURCES-1:0] req_i,
    output reg found_o,
    output reg [`IRQ_NUM_W-1:0] num_o
);

    integer i;

    // ***************************************
    // Scan from highest number down
    // ***************************************
    always @* begin
        found_o = 1'b0;
        num_o = {`IRQ_NUM_W{1'b0}};
        for (i = `IRQ_SOURCES - 1; i >= 0; i = i - 1) begin
            if (req_i[i]) begin
                found_o = 1'b1;
                num_o = i[`IRQ_NUM_W-1:0];
            end
        end
    end

endmodule // irq_pick

// ### hdl/irq_enable_priority_regs.v
// Interrupt enable and priority registers with two-level preemption control
//
// Overview of operation
// - Basic priority at 0xb8, bit-addressable, all pages
// - Basic priority bit 7 reads one, ignores writes
// - Bit 6 sets serial port interrupt priority
// - Bit 5 sets timer two interrupt priority
// - Bit 4 sets UART interrupt priority
// - Bits 3, 1 set timer one, zero priority
// - Bits 2, 0 set external one, zero priority
// - Extended enable at 0xe6, all pages, reset zero
// - Enable bit 7 gates LIN pending flag
// - Enable bit 6 gates timer three overflows
// - Bits 5, 4 gate comparator edge flags
// - Enable bit 3 gates counter array requests
// - Enable bit 2 gates conversion done flag
// - Enable bit 1 gates window compare flag
// - Enable bit 0 gates two-wire unit requests
// - Extended priority at 0xf6, pages 0/0x0f, reset zero
// - Bits 7, 6 set LIN, timer three priority
// - Bits 5, 4 set comparator priorities
// - Bit 3 sets counter array priority
// - Bit 2 sets conversion done priority
// - Bit 1 sets window compare priority
// - Bit 0 sets two-wire unit priority
// - Global enable gates every source on top of its individual mask
`timescale 1ns/10ps
`include "irq_prio_regs.vh"

module irq_enable_priority_regs (
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_page_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    input wire sfr_bit_wr_i,
    input wire [2:0] sfr_bit_sel_i,
    input wire sfr_bit_val_i,
    output reg [7:0] sfr_rdata_o,
    output reg sfr_rvalid_o,
    input wire global_irq_enable_i,
    input wire [6:0] basic_irq_en_i,
    input wire [6:0] basic_pending_i,
    input wire lin_pending_flag_i,
    input wire timer_three_low_overflow_i,
    input wire timer_three_high_overflow_i,
    input wire cmp_one_rise_flag_i,
    input wire cmp_one_fall_flag_i,
    input wire cmp_zero_rise_flag_i,
    input wire cmp_zero_fall_flag_i,
    input wire counter_array_flag_i,
    input wire conv_done_flag_i,
    input wire window_match_flag_i,
    input wire two_wire_flag_i,
    input wire vector_ack_i,
    input wire service_return_i,
    output reg irq_req_o,
    output reg [`IRQ_NUM_W-1:0] irq_num_o,
    output reg irq_high_o,
    output reg high_in_service_o,
    output reg low_in_service_o
);

    // ***************************************
    // Decode helpers
    // ***************************************
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    function prio_page_ok;
        input [7:0] page;
        begin
            prio_page_ok = (page == `SFR_PAGE_ZERO) || (page == `SFR_PAGE_CONFIG);
        end
    endfunction

    // Byte write wins over bit write
    function [7:0] merge_write;
        input [7:0] old;
        input byte_wr;
        input bit_wr;
        input [7:0] wdata;
        input [2:0] sel;
        input val;
        reg [7:0] tmp;
        begin
            tmp = old;
            if (byte_wr) begin
                tmp = wdata;
            end else if (bit_wr) begin
                tmp[sel] = val;
            end
            merge_write = tmp;
        end
    endfunction

    function level_free;
        input is_high;
        input high_busy;
        input low_busy;
        begin
            if (is_high) begin
                level_free = !high_busy;
            end else begin
                level_free = !high_busy && !low_busy;
            end
        end
    endfunction

    // ***************************************
    // Register storage
    // ***************************************
    reg [6:0] basic_prio_q;
    reg [6:0] basic_prio_d;
    reg [7:0] ext_en_q;
    reg [7:0] ext_prio_q;
    reg [7:0] ext_en_d;
    reg [7:0] ext_prio_d;
    reg [7:0] rdata_d;
    reg rvalid_d;
    wire en_byte_wr;
    wire en_bit_wr;
    wire ep_byte_wr;
    wire ep_bit_wr;
    wire ip_sel;
    wire en_sel;
    wire ep_sel;
    wire [7:0] basic_prio_read;

    assign ip_sel = hit(sfr_addr_i, `BASIC_IRQ_PRIORITY_ADDR);
    assign en_sel = hit(sfr_addr_i, `EXT_IRQ_ENABLE_ONE_ADDR);
    assign ep_sel = hit(sfr_addr_i, `EXT_IRQ_PRIORITY_ONE_ADDR) && prio_page_ok(sfr_page_i);
    assign basic_prio_read = {`BASIC_PRIO_UNUSED_READ, basic_prio_q};
    assign en_byte_wr = en_sel && sfr_wr_i;
    assign en_bit_wr = en_sel && sfr_bit_wr_i;
    assign ep_byte_wr = ep_sel && sfr_wr_i;
    assign ep_bit_wr = ep_sel && sfr_bit_wr_i;

    // ***************************************
    // Basic priority next value
    // ***************************************
    always @* begin
        basic_prio_d = basic_prio_q;
        if (ip_sel && sfr_wr_i) begin
            basic_prio_d = sfr_wdata_i[6:0];
        end else if (ip_sel && sfr_bit_wr_i &&
                     sfr_bit_sel_i != `BASIC_PRIO_UNUSED_BIT) begin
            basic_prio_d[sfr_bit_sel_i] = sfr_bit_val_i;
        end
    end

    // ***************************************
    // Extended register next values
    // ***************************************
    always @* begin
        ext_en_d = merge_write(ext_en_q, en_byte_wr, en_bit_wr,
                               sfr_wdata_i, sfr_bit_sel_i, sfr_bit_val_i);
        ext_prio_d = merge_write(ext_prio_q, ep_byte_wr, ep_bit_wr,
                                 sfr_wdata_i, sfr_bit_sel_i, sfr_bit_val_i);
    end

    // ***************************************
    // Register writes
    // ***************************************
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            basic_prio_q <= `BASIC_IRQ_PRIORITY_RST;
            ext_en_q <= `EXT_IRQ_ENABLE_ONE_RST;
            ext_prio_q <= `EXT_IRQ_PRIORITY_ONE_RST;
        end else if (ce_i) begin
            basic_prio_q <= basic_prio_d;
            ext_en_q <= ext_en_d;
            ext_prio_q <= ext_prio_d;
        end
    end

    // ***************************************
    // Register reads
    // ***************************************
    always @* begin
        rvalid_d = sfr_rd_i && (ip_sel || en_sel || ep_sel);
        rdata_d = 8'h00;
        if (sfr_rd_i && ip_sel) begin
            rdata_d = basic_prio_read;
        end else if (sfr_rd_i && en_sel) begin
            rdata_d = ext_en_q;
        end else if (sfr_rd_i && ep_sel) begin
            rdata_d = ext_prio_q;
        end
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            sfr_rdata_o <= rdata_d;
            sfr_rvalid_o <= rvalid_d;
        end
    end

    // ***************************************
    // Source gating
    // ***************************************
    wire [7:0] ext_flags;
    wire [7:0] ext_gated;
    wire [6:0] basic_gated;
    wire [`IRQ_SOURCES-1:0] pending;
    wire [`IRQ_SOURCES-1:0] prio;

    assign ext_flags[`LIN_IRQ_BIT] = lin_pending_flag_i;
    assign ext_flags[`TIMER_THREE_IRQ_BIT] = timer_three_low_overflow_i |
                                             timer_three_high_overflow_i;
    assign ext_flags[`CMP_ONE_IRQ_BIT] = cmp_one_rise_flag_i | cmp_one_fall_flag_i;
    assign ext_flags[`CMP_ZERO_IRQ_BIT] = cmp_zero_rise_flag_i | cmp_zero_fall_flag_i;
    assign ext_flags[`COUNTER_ARRAY_IRQ_BIT] = counter_array_flag_i;
    assign ext_flags[`CONV_DONE_IRQ_BIT] = conv_done_flag_i;
    assign ext_flags[`WINDOW_IRQ_BIT] = window_match_flag_i;
    assign ext_flags[`TWO_WIRE_IRQ_BIT] = two_wire_flag_i;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : ext_gate
            // Each enable bit masks its own source
            assign ext_gated[g] = ext_flags[g] & ext_en_q[g];
        end
        for (g = 0; g < 7; g = g + 1) begin : basic_gate
            assign basic_gated[g] = basic_pending_i[g] & basic_irq_en_i[g];
        end
    endgenerate

    assign pending = {ext_gated, basic_gated} & {`IRQ_SOURCES{global_irq_enable_i}};
    // Basic bits 0..6 and extended bits 7..14 pick their level
    assign prio = {ext_prio_q, basic_prio_q};

    // ***************************************
    // Level selection
    // ***************************************
    wire high_found;
    wire low_found;
    wire [`IRQ_NUM_W-1:0] high_num;
    wire [`IRQ_NUM_W-1:0] low_num;

    irq_pick high_pick (
        .req_i(pending & prio),
        .found_o(high_found),
        .num_o(high_num)
    );

    irq_pick low_pick (
        .req_i(pending & ~prio),
        .found_o(low_found),
        .num_o(low_num)
    );

    // ***************************************
    // Service tracking and request output
    // ***************************************
    reg high_ok;
    reg low_ok;

    always @* begin
        high_ok = high_found && level_free(1'b1, high_in_service_o, low_in_service_o);
        low_ok = low_found && level_free(1'b0, high_in_service_o, low_in_service_o);
    end

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            irq_req_o <= 1'b0;
            irq_num_o <= {`IRQ_NUM_W{1'b0}};
            irq_high_o <= 1'b0;
            high_in_service_o <= 1'b0;
            low_in_service_o <= 1'b0;
        end else if (ce_i) begin
            if (vector_ack_i && irq_req_o) begin
                irq_req_o <= 1'b0;
                if (irq_high_o) begin
                    high_in_service_o <= 1'b1;
                end else begin
                    low_in_service_o <= 1'b1;
                end
            end else begin
                if (service_return_i) begin
                    if (high_in_service_o) begin
                        high_in_service_o <= 1'b0;
                    end else begin
                        low_in_service_o <= 1'b0;
                    end
                end
                irq_req_o <= high_ok || low_ok;
                irq_high_o <= high_ok;
                irq_num_o <= high_ok ? high_num : low_num;
            end
        end
    end

endmodule // irq_enable_priority_regs

// ### testbench/irq_enable_priority_regs_monitor.sv
// Port checker for the interrupt enable and priority block
`timescale 1ns/10ps
module irq_enable_priority_regs_monitor (
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_page_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    input wire sfr_rvalid_o,
    input wire global_irq_enable_i,
    input wire [6:0] basic_irq_en_i,
    input wire [6:0] basic_pending_i,
    input wire lin_pending_flag_i,
    input wire timer_three_low_overflow_i,
    input wire timer_three_high_overflow_i,
    input wire cmp_one_rise_flag_i,
    input wire cmp_one_fall_flag_i,
    input wire cmp_zero_rise_flag_i,
    input wire cmp_zero_fall_flag_i,
    input wire counter_array_flag_i,
    input wire conv_done_flag_i,
    input wire window_match_flag_i,
    input wire two_wire_flag_i,
    input wire vector_ack_i,
    input wire service_return_i,
    input wire irq_req_o,
    input wire [3:0] irq_num_o,
    input wire irq_high_o,
    input wire high_in_service_o,
    input wire low_in_service_o
);
    // ****************************************
    // Helper logic
    // ****************************************
    wire pg_ok = sfr_page_i == 8'h00 || sfr_page_i == 8'h0f;
    wire hit = sfr_addr_i == 8'hb8 || sfr_addr_i == 8'he6 || (sfr_addr_i == 8'hf6 && pg_ok);
    wire [14:0] raw = {lin_pending_flag_i,
        timer_three_low_overflow_i | timer_three_high_overflow_i,
        cmp_one_rise_flag_i | cmp_one_fall_flag_i, cmp_zero_rise_flag_i | cmp_zero_fall_flag_i,
        counter_array_flag_i, conv_done_flag_i, window_match_flag_i, two_wire_flag_i,
        basic_pending_i & basic_irq_en_i};
    reg [14:0] raw_q;
    always @(posedge clk_i) begin
        if (ce_i) begin
            raw_q <= raw;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ****************************************
    // Assertions
    // ****************************************
    chk_rd_answer: assert property (ce_i && sfr_rd_i && hit |=> sfr_rvalid_o)
        else $error("read hit gave no valid");
    chk_rd_refused: assert property (ce_i && sfr_rd_i && !hit |=> !sfr_rvalid_o && sfr_rdata_o == 8'h00)
        else $error("refused read answered");
    chk_top_bit_one: assert property (ce_i && sfr_rd_i && sfr_addr_i == 8'hb8 |=> sfr_rdata_o[7])
        else $error("unused bit read zero");
    chk_src_cause: assert property (irq_req_o |-> raw_q[irq_num_o])
        else $error("request without enabled flag");
    chk_global_gate: assert property (ce_i && !global_irq_enable_i |=> !irq_req_o)
        else $error("request while globally disabled");
    chk_high_blocks: assert property (high_in_service_o |-> !irq_req_o)
        else $error("request during high service");
    chk_low_only_high: assert property (low_in_service_o && irq_req_o |-> irq_high_o)
        else $error("low request during low service");
    chk_ack_low: assert property (ce_i && vector_ack_i && irq_req_o && !irq_high_o
        |=> !irq_req_o && low_in_service_o)
        else $error("low ack not taken");
    chk_ack_high: assert property (ce_i && vector_ack_i && irq_req_o && irq_high_o
        |=> high_in_service_o && !irq_req_o)
        else $error("high ack not taken");
    chk_high_held: assert property (high_in_service_o && !(ce_i && service_return_i)
        |=> high_in_service_o)
        else $error("high service dropped early");
    cov_preempt: cover property (vector_ack_i && irq_req_o && irq_high_o && low_in_service_o);
    cov_read: cover property (sfr_rvalid_o);
    cov_return: cover property (service_return_i && high_in_service_o);
endmodule // irq_enable_priority_regs_monitor
bind irq_enable_priority_regs irq_enable_priority_regs_monitor u_mon (.*);

// ### testbench/cpu_model.sv
// CPU side model: takes presented requests and returns from service
`timescale 1ns/10ps
module cpu_model (
    input wire clk_i,
    input wire nrst_i,
    input wire irq_req_i,
    input wire [7:0] ret_dly_i,
    output logic ack_o,
    output logic ret_o
);
    integer depth = 0;
    integer cnt = 0;
    initial ack_o = 1'b0;
    initial ret_o = 1'b0;
    always @(negedge clk_i) begin
        ack_o <= 1'b0;
        ret_o <= 1'b0;
        if (!nrst_i) begin
            depth = 0;
        end else if (irq_req_i && !ack_o) begin
            ack_o <= 1'b1;
            depth = depth + 1;
            cnt = ret_dly_i;
        end else if (depth > 0 && !ret_o) begin
            cnt = cnt - 1;
            if (cnt < 0) begin
                ret_o <= 1'b1;
                depth = depth - 1;
                cnt = ret_dly_i;
            end
        end
    end
endmodule // cpu_model

// ### testbench/irq_enable_priority_regs_tb_top.sv
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/10ps
module irq_enable_priority_regs_tb_top;
    logic clk_i, nrst_i, ce_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i;
    logic global_irq_enable_i, alt, h;
    logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, v, dly, en_x, pr_x, pr_b;
    logic [2:0] sfr_bit_sel_i;
    logic [6:0] basic_irq_en_i;
    logic [14:0] src;
    wire [7:0] sfr_rdata_o;
    wire [3:0] irq_num_o;
    wire sfr_rvalid_o, vector_ack_i, service_return_i, irq_req_o, irq_high_o;
    wire high_in_service_o, low_in_service_o;
    wire [6:0] basic_pending_i = src[6:0];
    wire two_wire_flag_i = src[7];
    wire window_match_flag_i = src[8];
    wire conv_done_flag_i = src[9];
    wire counter_array_flag_i = src[10];
    wire cmp_zero_rise_flag_i = src[11] & ~alt;
    wire cmp_zero_fall_flag_i = src[11] & alt;
    wire cmp_one_rise_flag_i = src[12] & ~alt;
    wire cmp_one_fall_flag_i = src[12] & alt;
    wire timer_three_low_overflow_i = src[13] & ~alt;
    wire timer_three_high_overflow_i = src[13] & alt;
    wire lin_pending_flag_i = src[14];
    integer seed = 8;
    integer fail_count = 0;
    integer n_checks = 0;
    integer s;
    logic [7:0] rq[$];
    logic [4:0] iq[$];
    irq_enable_priority_regs dut (.*);
    cpu_model u_cpu (.clk_i(clk_i), .nrst_i(nrst_i), .irq_req_i(irq_req_o), .ret_dly_i(dly),
        .ack_o(vector_ack_i), .ret_o(service_return_i));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task report(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cmp_rd(input logic [7:0] g);
        report(g, rq.size() > 0 ? rq.pop_front() : 8'hxx);
    endtask
    task cmp_irq(input logic [4:0] g);
        report({3'h0, g}, iq.size() > 0 ? {3'h0, iq.pop_front()} : 8'hxx);
    endtask
    task sfr(input logic [1:0] op, input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(negedge clk_i);
        {sfr_addr_i, sfr_page_i, sfr_wdata_i} = {a, p, d};
        {sfr_bit_val_i, sfr_bit_sel_i} = d[3:0];
        {sfr_bit_wr_i, sfr_rd_i, sfr_wr_i} = 3'b001 << op;
        @(negedge clk_i);
        {sfr_bit_wr_i, sfr_rd_i, sfr_wr_i} = 3'b000;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
        rq.push_back(e);
        sfr(2'd1, a, p, 8'h00);
    endtask
    task arm(input integer n, input logic hi);
        if (n < 7) begin
            basic_irq_en_i[n] = 1'b1;
            pr_b[n] = hi;
            sfr(2'd0, 8'hb8, 8'h00, pr_b);
        end else begin
            en_x[n-7] = 1'b1;
            pr_x[n-7] = hi;
            sfr(2'd0, 8'he6, 8'h00, en_x);
            sfr(2'd0, 8'hf6, 8'h0f, pr_x);
        end
    endtask
    task take(input integer n);
        integer i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk_i);
            if (vector_ack_i === 1'b1) break;
        end
        if (i == 200) fail_count++;
        @(negedge clk_i);
        src[n] = 1'b0;
    endtask
    task idle;
        integer i;
        for (i = 0; i < 300; i++) begin
            @(negedge clk_i);
            if ({high_in_service_o, low_in_service_o, irq_req_o} === 3'b000) break;
        end
    endtask
    task print_verdict;
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Checking and stimulus
    // ****************************************
    always @(posedge clk_i) begin
        if (ce_i === 1'b1 && sfr_rvalid_o === 1'b1) cmp_rd(sfr_rdata_o);
        if (ce_i === 1'b1 && vector_ack_i === 1'b1 && irq_req_o === 1'b1)
            cmp_irq({irq_high_o, irq_num_o});
    end
    initial begin
        #(25 * 20000);
        fail_count++;
        print_verdict;
    end
    initial begin
        {nrst_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i, alt} = 6'h00;
        {ce_i, global_irq_enable_i, dly} = {2'b11, 8'h02};
        {sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_bit_sel_i} = 27'h0;
        {basic_irq_en_i, src, en_x, pr_x, pr_b} = 46'h0;
        repeat (8) @(negedge clk_i);
        nrst_i = 1'b1;
        rd(8'hb8, 8'h00, 8'h80);
        rd(8'he6, 8'h33, 8'h00);
        rd(8'hf6, 8'h0f, 8'h00);
        v = $random(seed);
        sfr(2'd0, 8'hb8, 8'h21, v);
        rd(8'hb8, 8'h5c, v | 8'h80);
        sfr(2'd2, 8'hb8, 8'h00, {4'h0, ~v[6], 3'd6});
        rd(8'hb8, 8'h00, {1'b1, ~v[6], v[5:0]});
        sfr(2'd0, 8'he6, 8'h44, v);
        rd(8'he6, 8'h07, v);
        sfr(2'd0, 8'hf6, 8'h05, v);
        rd(8'hf6, 8'h00, 8'h00);
        sfr(2'd0, 8'hf6, 8'h00, v);
        rd(8'hf6, 8'h0f, v);
        sfr(2'd1, 8'hf6, 8'h05, 8'h00);
        sfr(2'd1, 8'ha7, 8'h00, 8'h00);
        sfr(2'd0, 8'hb8, 8'h00, 8'h00);
        sfr(2'd0, 8'he6, 8'h00, 8'h00);
        sfr(2'd0, 8'hf6, 8'h00, 8'h00);
        for (s = 0; s < 15; s++) begin
            h = $random(seed);
            alt = $random(seed);
            arm(s, h);
            iq.push_back({h, s[3:0]});
            src[s] = 1'b1;
            take(s);
            idle;
        end
        basic_irq_en_i = 7'h00;
        sfr(2'd0, 8'he6, 8'h00, 8'h7f);
        src[14] = 1'b1;
        repeat (4) @(negedge clk_i);
        report({7'h0, irq_req_o}, 8'h00);
        src[14] = 1'b0;
        global_irq_enable_i = 1'b0;
        src[9] = 1'b1;
        repeat (4) @(negedge clk_i);
        report({7'h0, irq_req_o}, 8'h00);
        iq.push_back({pr_x[2], 4'd9});
        global_irq_enable_i = 1'b1;
        take(9);
        idle;
        dly = 8'd40;
        sfr(2'd0, 8'he6, 8'h00, 8'hff);
        sfr(2'd0, 8'hf6, 8'h00, 8'h80);
        iq.push_back(5'h1e);
        iq.push_back(5'h09);
        src = 15'h4200;
        take(14);
        take(9);
        idle;
        iq.push_back(5'h09);
        iq.push_back(5'h1e);
        src[9] = 1'b1;
        take(9);
        src[14] = 1'b1;
        take(14);
        idle;
        iq.push_back(5'h07);
        iq.push_back(5'h09);
        src = 15'h0280;
        take(7);
        take(9);
        idle;
        // Frozen write must not land
        ce_i = 1'b0;
        sfr(2'd0, 8'he6, 8'h00, 8'h00);
        ce_i = 1'b1;
        rd(8'he6, 8'h00, 8'hff);
        // Second reset in mid-run
        nrst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        rd(8'hb8, 8'h00, 8'h80);
        rd(8'he6, 8'h00, 8'h00);
        rd(8'hf6, 8'h0f, 8'h00);
        repeat (2) @(negedge clk_i);
        if (rq.size() + iq.size() > 0) fail_count++;
        print_verdict;
    end
endmodule // irq_enable_priority_regs_tb_top
